// ===== mabce_pkg.sv
// constants and types for the 8-bit core execution and decode block
// assumes a single 100 MHz clock domain shared by program and data memory
`default_nettype none

package mabce_pkg;

	localparam int PC_W        = 12;
	localparam int STACK_DEPTH = 6;
	localparam int STK_W       = PC_W + 2;

	localparam logic [2:0]  SP_EMPTY   = 3'h0;
	localparam logic [2:0]  SP_FULL    = 3'h6;
	localparam logic [11:0] RESET_PC   = 12'h000;
	localparam logic [7:0]  IDX_X_ADDR = 8'h80;
	localparam logic [7:0]  SD_BASE    = 8'h80;
	localparam logic [7:0]  ACC_ADDR   = 8'hFF;

	// opcode field positions
	localparam int F_COND_HI = 2;
	localparam int F_COND_LO = 0;
	localparam int F_DIR     = 3;
	localparam int F_SPAN_HI = 7;
	localparam int F_SPAN_LO = 4;
	localparam int F_BIT_HI  = 7;
	localparam int F_BIT_LO  = 5;
	localparam int F_POL     = 4;
	localparam int F_IDX     = 4;
	localparam int F_MODE    = 4;
	localparam int F_REG_HI  = 7;
	localparam int F_REG_LO  = 6;
	localparam int F_GRP_HI  = 5;
	localparam int F_GRP_LO  = 4;
	localparam int F_NIB_HI  = 3;
	localparam int F_NIB_LO  = 0;

	// low nibble codes
	localparam logic [2:0] LOW_CALLJP = 3'h1;
	localparam logic [3:0] NIB_BTB    = 4'h3;
	localparam logic [3:0] NIB_BSR    = 4'hB;
	localparam logic [3:0] NIB_INC    = 4'h5;
	localparam logic [3:0] NIB_DEC    = 4'hD;
	localparam logic [3:0] NIB_IND    = 4'h7;
	localparam logic [3:0] NIB_DIR    = 4'hF;

	// short branch conditions
	localparam logic [2:0] COND_NZ = 3'h0;
	localparam logic [2:0] COND_NC = 3'h2;
	localparam logic [2:0] COND_Z  = 3'h4;
	localparam logic [2:0] COND_C  = 3'h6;

	// arithmetic group operation field
	localparam logic [2:0] ALU_ADD = 3'h0;
	localparam logic [2:0] ALU_AND = 3'h1;
	localparam logic [2:0] ALU_CP  = 3'h2;
	localparam logic [2:0] ALU_SUB = 3'h3;
	localparam logic [2:0] ALU_INC = 3'h4;
	localparam logic [2:0] ALU_DEC = 3'h5;
	localparam logic [2:0] ALU_CLR = 3'h6;
	localparam logic [2:0] ALU_ACC = 3'h7;

	localparam logic [7:0] OP_CPL_ACC     = 8'hE7;
	localparam logic [7:0] OP_ROT_CARRY   = 8'hF7;
	localparam logic [7:0] OP_SHIFT_ARITH = 8'hEF;

	// control group: group field 1 selects by register field, 2 is wait
	localparam logic [1:0] GRP_SDI  = 2'h0;
	localparam logic [1:0] GRP_CTL  = 2'h1;
	localparam logic [1:0] GRP_WAIT = 2'h2;
	localparam logic [1:0] CTL_NOP  = 2'h0;
	localparam logic [1:0] CTL_RET  = 2'h1;
	localparam logic [1:0] CTL_RET_INT = 2'h2;
	localparam logic [1:0] CTL_STOP = 2'h3;

	localparam logic [11:0] LEN_1 = 12'h001;
	localparam logic [11:0] LEN_2 = 12'h002;
	localparam logic [11:0] LEN_3 = 12'h003;

	localparam logic [2:0] CYC_FIRST = 3'h1;
	localparam logic [2:0] CYC_SHORT = 3'h2;
	localparam logic [2:0] CYC_STD   = 3'h4;
	localparam logic [2:0] CYC_BTB   = 3'h5;

	typedef enum logic [2:0] {
		ST_FETCH, ST_DECODE, ST_PTR, ST_OPER, ST_PAD, ST_HALT
	} mabce_state_t;

	typedef enum logic [2:0] {
		CL_REL, CL_JMP, CL_BTB, CL_BSR, CL_SDI, CL_ALU, CL_ACC
	} mabce_class_t;

endpackage

`default_nettype wire

// ===== mabce_core.sv
// execution and decode core: arithmetic, branches, bit ops, control
// assumes program and data memory answer in the same cycle as the request
//
// Operation
// - add, and, compare, subtract use accumulator and memory or immediate byte.
// - clear, decrement, increment reach any of 256 data addresses.
// - complement, rotate and shift act on the accumulator only.
// - add, and, compare, subtract take 4 cycles, update zero and carry.
// - increment and decrement take 4 cycles, update zero, keep carry.
// - memory clear is 3 bytes, 4 cycles, no flags; accumulator clear 2 bytes.
// - shift is 2 bytes; complement, rotate 1 byte; 4 cycles, both flags.
// - conditional branches jump only when condition holds, else fall through.
// - four short branches on carry and zero, 1 byte, 2 cycles, flags kept.
// - short displacement spans -15 to +16 locations.
// - bit-test branches on bit clear or set, 3 bytes, 5 cycles.
// - bit-test displacement is 8-bit signed, range -126 to +129.
// - bit-test copies tested bit into carry, zero unchanged.
// - bit set or clear reaches any bit of any data location.
// - bit set and clear are 2 bytes, 4 cycles, flags kept.
// - bit number is a 3-bit opcode field.
// - jump and call use a full 12-bit target.
// - no-op, return, wait, stop: 1 byte, 2 cycles, flags kept.
// - return from interrupt is 1 byte, 2 cycles, restores both flags.
// - with watchdog selected, stop acts as wait.
// - short branch opcode holds condition, direction bit and 4-bit span.
// - indirect forms take address from 80h or 81h by opcode bit 4.
// - short direct forms reach 80h to 83h selected by opcode.
`default_nettype none

module mabce_core (
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic [23:0] PM_DATA_I,
	input  wire logic [7:0]  DS_RDATA_I,
	input  wire logic        WDOG_SEL_I,
	input  wire logic        WAKE_I,
	output logic      [11:0] PM_ADDR_O,
	output logic             PM_RD_O,
	output logic      [7:0]  DS_ADDR_O,
	output logic             DS_RD_O,
	output logic             DS_WR_O,
	output logic      [7:0]  DS_WDATA_O,
	output logic      [7:0]  ACC_O,
	output logic             ZERO_O,
	output logic             CARRY_O,
	output logic      [11:0] PC_O,
	output logic             WAIT_O,
	output logic             STOP_O,
	output logic             DONE_O
);

	typedef struct packed {
		mabce_pkg::mabce_state_t                   st;
		logic [2:0]                                cnt;
		logic [2:0]                                lim;
		logic [11:0]                               pc;
		logic [11:0]                               ipc;
		logic [11:0]                               tgt;
		logic [7:0]                                op;
		logic [7:0]                                b1;
		logic [7:0]                                b2;
		logic [7:0]                                addr;
		logic                                      imm;
		logic [7:0]                                acc;
		logic                                      z;
		logic                                      c;
		logic [mabce_pkg::STACK_DEPTH-1:0]
			[mabce_pkg::STK_W-1:0]                 stk;
		logic [2:0]                                sp;
		logic [11:0]                               pm_addr;
		logic                                      pm_rd;
		logic [7:0]                                ds_addr;
		logic                                      ds_rd;
		logic                                      ds_wr;
		logic [7:0]                                ds_wdata;
		logic                                      wait_md;
		logic                                      stop_md;
		logic                                      done;
		logic                                      wd_s1;
		logic                                      wd_s2;
		logic                                      wk_s1;
		logic                                      wk_s2;
	} mabce_regs_t;

	localparam mabce_regs_t RST_VAL = '{
		st:      mabce_pkg::ST_FETCH,
		cnt:     mabce_pkg::CYC_FIRST,
		pm_addr: mabce_pkg::RESET_PC,
		pc:      mabce_pkg::RESET_PC,
		pm_rd:   1'b1,
		default: '0
	};

	mabce_regs_t cur;
	mabce_regs_t nx;

	function automatic mabce_pkg::mabce_class_t f_class(
		input logic [7:0] op
	);
		logic [3:0] nib;
		nib = op[mabce_pkg::F_NIB_HI:mabce_pkg::F_NIB_LO];
		if (!nib[0])
			return mabce_pkg::CL_REL;
		if (nib[2:0] == mabce_pkg::LOW_CALLJP)
			return mabce_pkg::CL_JMP;
		if (nib == mabce_pkg::NIB_BTB)
			return mabce_pkg::CL_BTB;
		if (nib == mabce_pkg::NIB_BSR)
			return mabce_pkg::CL_BSR;
		if (nib == mabce_pkg::NIB_INC || nib == mabce_pkg::NIB_DEC)
			return mabce_pkg::CL_SDI;
		if (op[mabce_pkg::F_BIT_HI:mabce_pkg::F_BIT_LO] == mabce_pkg::ALU_ACC)
			return mabce_pkg::CL_ACC;
		return mabce_pkg::CL_ALU;
	endfunction

	function automatic logic f_cond(
		input logic [2:0] cond,
		input logic       z,
		input logic       c
	);
		case (cond)
			mabce_pkg::COND_NZ: return !z;
			mabce_pkg::COND_NC: return !c;
			mabce_pkg::COND_Z:  return z;
			mabce_pkg::COND_C:  return c;
			default:            return 1'b0;
		endcase
	endfunction

	// ends the instruction and starts the fetch of the next one
	function automatic mabce_regs_t f_finish(
		input mabce_regs_t s,
		input logic [11:0] npc
	);
		mabce_regs_t r;
		r = s;
		r.pc = npc;
		r.pm_addr = npc;
		r.pm_rd = 1'b1;
		r.st = mabce_pkg::ST_FETCH;
		r.cnt = mabce_pkg::CYC_FIRST;
		r.done = 1'b1;
		return r;
	endfunction

	// the accumulator lives here; other addresses go out as a write
	function automatic mabce_regs_t f_wb(
		input mabce_regs_t s,
		input logic [7:0]  a,
		input logic [7:0]  v
	);
		mabce_regs_t r;
		r = s;
		if (a == mabce_pkg::ACC_ADDR) begin
			r.acc = v;
		end else begin
			r.ds_wr = 1'b1;
			r.ds_addr = a;
			r.ds_wdata = v;
		end
		return r;
	endfunction

	always_comb begin
		mabce_pkg::mabce_class_t cls;
		logic [7:0]  opnd;
		logic [8:0]  rslt;
		logic [11:0] tgt;
		logic [11:0] span;
		logic [2:0]  bsel;
		logic [2:0]  aop;
		logic [2:0]  idx;
		logic        bitv;
		nx = cur;
		cls = f_class(cur.op);
		opnd = cur.imm ? cur.b1 :
			(cur.addr == mabce_pkg::ACC_ADDR ? cur.acc : DS_RDATA_I);
		rslt = '0;
		tgt = cur.tgt;
		span = {8'h00, cur.op[mabce_pkg::F_SPAN_HI:mabce_pkg::F_SPAN_LO]};
		bsel = cur.op[mabce_pkg::F_BIT_HI:mabce_pkg::F_BIT_LO];
		aop = cur.op[mabce_pkg::F_BIT_HI:mabce_pkg::F_BIT_LO];
		idx = cur.sp - 3'h1;
		bitv = 1'b0;
		nx.wd_s1 = WDOG_SEL_I;
		nx.wd_s2 = cur.wd_s1;
		nx.wk_s1 = WAKE_I;
		nx.wk_s2 = cur.wk_s1;
		nx.pm_rd = 1'b0;
		nx.ds_rd = 1'b0;
		nx.ds_wr = 1'b0;
		nx.done = 1'b0;
		nx.cnt = cur.cnt + 3'h1;
		case (cur.st)
			mabce_pkg::ST_FETCH: begin
				nx.op = PM_DATA_I[7:0];
				nx.b1 = PM_DATA_I[15:8];
				nx.b2 = PM_DATA_I[23:16];
				nx.ipc = cur.pc;
				nx.imm = 1'b0;
				nx.lim = mabce_pkg::CYC_STD;
				nx.st = mabce_pkg::ST_DECODE;
			end
			mabce_pkg::ST_DECODE: begin
				case (cls)
					mabce_pkg::CL_REL: begin
						tgt = cur.op[mabce_pkg::F_DIR] ? cur.ipc - span
							: cur.ipc + mabce_pkg::LEN_1 + span;
						nx = f_finish(nx, f_cond(
							cur.op[mabce_pkg::F_COND_HI:mabce_pkg::F_COND_LO],
							cur.z, cur.c) ? tgt
							: cur.ipc + mabce_pkg::LEN_1);
					end
					mabce_pkg::CL_JMP: begin
						if (!cur.op[mabce_pkg::F_DIR]
								&& cur.sp != mabce_pkg::SP_FULL) begin
							nx.stk[cur.sp] = {cur.z, cur.c,
								cur.ipc + mabce_pkg::LEN_2};
							nx.sp = cur.sp + 3'h1;
						end
						nx.tgt = {cur.op[mabce_pkg::F_SPAN_HI:mabce_pkg::F_SPAN_LO],
							cur.b1};
						nx.st = mabce_pkg::ST_PAD;
					end
					mabce_pkg::CL_BTB, mabce_pkg::CL_BSR: begin
						nx.ds_addr = cur.b1;
						nx.addr = cur.b1;
						nx.ds_rd = (cur.b1 != mabce_pkg::ACC_ADDR);
						nx.lim = (cls == mabce_pkg::CL_BTB) ? mabce_pkg::CYC_BTB
							: mabce_pkg::CYC_STD;
						nx.tgt = cur.ipc + mabce_pkg::LEN_2;
						nx.st = mabce_pkg::ST_OPER;
					end
					mabce_pkg::CL_SDI: begin
						case (cur.op[mabce_pkg::F_GRP_HI:mabce_pkg::F_GRP_LO])
							mabce_pkg::GRP_SDI: begin
								nx.addr = mabce_pkg::SD_BASE | {6'h00,
									cur.op[mabce_pkg::F_REG_HI:mabce_pkg::F_REG_LO]};
								nx.ds_addr = nx.addr;
								nx.ds_rd = 1'b1;
								nx.tgt = cur.ipc + mabce_pkg::LEN_1;
								nx.st = mabce_pkg::ST_OPER;
							end
							mabce_pkg::GRP_CTL: begin
								nx = f_finish(nx, cur.ipc + mabce_pkg::LEN_1);
								case (cur.op[mabce_pkg::F_REG_HI:mabce_pkg::F_REG_LO])
									mabce_pkg::CTL_RET, mabce_pkg::CTL_RET_INT: begin
										if (cur.sp != mabce_pkg::SP_EMPTY) begin
											nx = f_finish(nx,
												cur.stk[idx][mabce_pkg::PC_W-1:0]);
											nx.sp = idx;
											if (cur.op[mabce_pkg::F_REG_HI]) begin
												nx.z = cur.stk[idx][mabce_pkg::STK_W-1];
												nx.c = cur.stk[idx][mabce_pkg::PC_W];
											end
										end else begin
											nx = f_finish(nx, mabce_pkg::RESET_PC);
										end
									end
									mabce_pkg::CTL_STOP: begin
										nx.st = mabce_pkg::ST_HALT;
										nx.pm_rd = 1'b0;
										nx.done = 1'b0;
										nx.stop_md = !cur.wd_s2;
										nx.wait_md = cur.wd_s2;
									end
									default: ;
								endcase
							end
							mabce_pkg::GRP_WAIT: begin
								nx = f_finish(nx, cur.ipc + mabce_pkg::LEN_1);
								nx.st = mabce_pkg::ST_HALT;
								nx.pm_rd = 1'b0;
								nx.done = 1'b0;
								nx.wait_md = 1'b1;
							end
							default: nx = f_finish(nx, cur.ipc + mabce_pkg::LEN_1);
						endcase
					end
					mabce_pkg::CL_ACC: begin
						nx.st = mabce_pkg::ST_PAD;
						nx.tgt = cur.ipc + mabce_pkg::LEN_1;
						case (cur.op)
							mabce_pkg::OP_CPL_ACC: begin
								rslt = {cur.acc[7], ~cur.acc};
							end
							mabce_pkg::OP_ROT_CARRY: begin
								rslt = {cur.acc, cur.c};
							end
							mabce_pkg::OP_SHIFT_ARITH: begin
								rslt = {cur.acc, 1'b0};
								nx.tgt = cur.ipc + mabce_pkg::LEN_2;
							end
							default: rslt = {cur.c, cur.acc};
						endcase
						nx.acc = rslt[7:0];
						nx.c = rslt[8];
						nx.z = (rslt[7:0] == 8'h00);
					end
					default: begin
						nx.tgt = cur.ipc + mabce_pkg::LEN_2;
						nx.st = mabce_pkg::ST_OPER;
						if (cur.op[mabce_pkg::F_NIB_HI:mabce_pkg::F_NIB_LO]
								== mabce_pkg::NIB_IND) begin
							nx.ds_addr = mabce_pkg::IDX_X_ADDR
								| {7'h00, cur.op[mabce_pkg::F_IDX]};
							nx.ds_rd = 1'b1;
							nx.tgt = cur.ipc + mabce_pkg::LEN_1;
							nx.st = mabce_pkg::ST_PTR;
						end else if (aop == mabce_pkg::ALU_CLR) begin
							nx.st = mabce_pkg::ST_PAD;
							if (cur.op[mabce_pkg::F_MODE]) begin
								nx = f_wb(nx, cur.b1, 8'h00);
								nx.tgt = cur.ipc + mabce_pkg::LEN_3;
							end else begin
								nx.acc = 8'h00;
								nx.z = 1'b1;
								nx.c = 1'b0;
							end
						end else if (cur.op[mabce_pkg::F_MODE]
								&& aop != mabce_pkg::ALU_INC
								&& aop != mabce_pkg::ALU_DEC) begin
							nx.imm = 1'b1;
						end else begin
							nx.addr = cur.b1;
							nx.ds_addr = cur.b1;
							nx.ds_rd = (cur.b1 != mabce_pkg::ACC_ADDR);
						end
					end
				endcase
			end
			mabce_pkg::ST_PTR: begin
				nx.addr = DS_RDATA_I;
				nx.ds_addr = DS_RDATA_I;
				nx.ds_rd = (DS_RDATA_I != mabce_pkg::ACC_ADDR);
				nx.st = mabce_pkg::ST_OPER;
			end
			mabce_pkg::ST_OPER: begin
				case (cls)
					mabce_pkg::CL_BTB: begin
						bitv = opnd[bsel];
						nx.c = bitv;
						tgt = (bitv == cur.op[mabce_pkg::F_POL])
							? cur.ipc + mabce_pkg::LEN_2 + 12'($signed(cur.b2))
							: cur.ipc + mabce_pkg::LEN_3;
					end
					mabce_pkg::CL_BSR: begin
						rslt = {1'b0, opnd};
						rslt[bsel] = cur.op[mabce_pkg::F_POL];
						nx = f_wb(nx, cur.addr, rslt[7:0]);
					end
					mabce_pkg::CL_SDI: begin
						rslt = cur.op[mabce_pkg::F_DIR] ? {1'b0, opnd - 8'h01}
							: {1'b0, opnd + 8'h01};
						nx = f_wb(nx, cur.addr, rslt[7:0]);
						nx.z = (rslt[7:0] == 8'h00);
					end
					default: begin
						case (aop)
							mabce_pkg::ALU_ADD: rslt = {1'b0, cur.acc} + {1'b0, opnd};
							mabce_pkg::ALU_AND: rslt = {1'b0, cur.acc & opnd};
							mabce_pkg::ALU_INC: rslt = {cur.c, opnd + 8'h01};
							mabce_pkg::ALU_DEC: rslt = {cur.c, opnd - 8'h01};
							default: rslt = {1'b0, cur.acc} - {1'b0, opnd};
						endcase
						nx.z = (rslt[7:0] == 8'h00);
						nx.c = rslt[8];
						if (aop == mabce_pkg::ALU_INC
								|| aop == mabce_pkg::ALU_DEC) begin
							nx = f_wb(nx, cur.addr, rslt[7:0]);
						end else if (aop != mabce_pkg::ALU_CP) begin
							nx.acc = rslt[7:0];
						end
					end
				endcase
				if (cur.cnt == cur.lim) begin
					nx = f_finish(nx, tgt);
				end else begin
					nx.tgt = tgt;
					nx.st = mabce_pkg::ST_PAD;
				end
			end
			mabce_pkg::ST_PAD: begin
				if (cur.cnt == cur.lim)
					nx = f_finish(nx, cur.tgt);
			end
			mabce_pkg::ST_HALT: begin
				nx.cnt = cur.cnt;
				if (cur.wk_s2) begin
					nx = f_finish(nx, cur.pc);
					nx.done = 1'b0;
					nx.wait_md = 1'b0;
					nx.stop_md = 1'b0;
				end
			end
			default: nx = RST_VAL;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I)
			cur <= RST_VAL;
		else
			cur <= nx;
	end

	assign PM_ADDR_O  = cur.pm_addr;
	assign PM_RD_O    = cur.pm_rd;
	assign DS_ADDR_O  = cur.ds_addr;
	assign DS_RD_O    = cur.ds_rd;
	assign DS_WR_O    = cur.ds_wr;
	assign DS_WDATA_O = cur.ds_wdata;
	assign ACC_O      = cur.acc;
	assign ZERO_O     = cur.z;
	assign CARRY_O    = cur.c;
	assign PC_O       = cur.pc;
	assign WAIT_O     = cur.wait_md;
	assign STOP_O     = cur.stop_md;
	assign DONE_O     = cur.done;

endmodule // mabce_core

`default_nettype wire

// ===== mabce_props.sv
// assertion checker for the execution core, attached to it by bind
// assumes one clock domain with RST_I asynchronous and active high
`default_nettype none

module mabce_props (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic [23:0] PM_DATA_I,
	input wire logic [7:0]  DS_RDATA_I,
	input wire logic        WDOG_SEL_I,
	input wire logic        WAKE_I,
	input wire logic [11:0] PM_ADDR_O,
	input wire logic        PM_RD_O,
	input wire logic [7:0]  DS_ADDR_O,
	input wire logic        DS_RD_O,
	input wire logic        DS_WR_O,
	input wire logic [7:0]  DS_WDATA_O,
	input wire logic [7:0]  ACC_O,
	input wire logic        ZERO_O,
	input wire logic        CARRY_O,
	input wire logic [11:0] PC_O,
	input wire logic        WAIT_O,
	input wire logic        STOP_O,
	input wire logic        DONE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_fetch_pulse: assert property (PM_RD_O |=> !PM_RD_O)
		else $error("fetch strobe longer than one cycle");
	a_instr_bound: assert property (
		PM_RD_O |-> ##[2:5] (PM_RD_O || WAIT_O || STOP_O))
		else $error("instruction longer than five cycles");
	a_done_fetch: assert property (
		DONE_O |-> PM_RD_O && PC_O == PM_ADDR_O)
		else $error("done pulse outside a fetch or pc mismatch");
	a_flags_hold: assert property (
		$past(PM_RD_O) |-> $stable(ZERO_O) && $stable(CARRY_O))
		else $error("flags changed at end of fetch cycle");
	a_halt_quiet: assert property (
		(WAIT_O || STOP_O) |-> !PM_RD_O && !DS_RD_O && !DS_WR_O)
		else $error("bus activity while halted");
	a_halt_frozen: assert property (
		WAIT_O && $past(WAIT_O) |-> $stable(ACC_O) && $stable(PC_O)
			&& $stable(ZERO_O) && $stable(CARRY_O))
		else $error("state moved while waiting");
	a_one_halt: assert property (!(WAIT_O && STOP_O))
		else $error("wait and stop together");
	a_wdog_no_stop: assert property (
		WDOG_SEL_I && $past(WDOG_SEL_I) && $past(WDOG_SEL_I, 2)
			&& $past(WDOG_SEL_I, 3) |-> !$rose(STOP_O))
		else $error("stop entered with watchdog selected");
	a_acc_off_bus: assert property (
		(DS_RD_O || DS_WR_O) |-> DS_ADDR_O != 8'hFF)
		else $error("accumulator address on data bus");
	a_write_single: assert property (DS_WR_O |=> !DS_WR_O)
		else $error("data write strobe longer than one cycle");

	c_halt_wait: cover property (WAIT_O);
	c_halt_stop: cover property (STOP_O);
	c_late_write: cover property (DS_WR_O && PM_RD_O);
endmodule // mabce_props

bind mabce_core mabce_props u_mabce_props (
	.CLK_I(CLK_I), .RST_I(RST_I), .PM_DATA_I(PM_DATA_I),
	.DS_RDATA_I(DS_RDATA_I), .WDOG_SEL_I(WDOG_SEL_I), .WAKE_I(WAKE_I),
	.PM_ADDR_O(PM_ADDR_O), .PM_RD_O(PM_RD_O), .DS_ADDR_O(DS_ADDR_O),
	.DS_RD_O(DS_RD_O), .DS_WR_O(DS_WR_O), .DS_WDATA_O(DS_WDATA_O),
	.ACC_O(ACC_O), .ZERO_O(ZERO_O), .CARRY_O(CARRY_O), .PC_O(PC_O),
	.WAIT_O(WAIT_O), .STOP_O(STOP_O), .DONE_O(DONE_O)
);

`default_nettype wire

// ===== mabce_mem.sv
// behavioural program and data memory facing the execution core
// assumes zero-latency answers in the cycle of each read strobe
`default_nettype none

module mabce_mem (
	input  wire logic        clk_i,
	input  wire logic [11:0] pm_addr_i,
	input  wire logic        pm_rd_i,
	output logic      [23:0] pm_data_o,
	input  wire logic [7:0]  ds_addr_i,
	input  wire logic        ds_rd_i,
	input  wire logic        ds_wr_i,
	input  wire logic [7:0]  ds_wdata_i,
	output logic      [7:0]  ds_rdata_o
);
	logic [7:0]  pm [4096];
	logic [7:0]  ds [256];
	logic [23:0] pm_word;
	logic [23:0] pm_last = 24'h000000;
	logic [7:0]  ds_last = 8'h00;

	initial begin
		for (int k = 0; k < 4096; k++)
			pm[k] = 8'h00;
	end
	assign pm_word = {pm[pm_addr_i + 12'h002], pm[pm_addr_i + 12'h001],
		pm[pm_addr_i]};
	// off strobe the buses show the inverse of the last answer
	assign pm_data_o = pm_rd_i ? pm_word : ~pm_last;
	assign ds_rdata_o = ds_rd_i ? ds[ds_addr_i] : ~ds_last;
	always @(posedge clk_i) begin
		if (pm_rd_i)
			pm_last <= pm_word;
		if (ds_rd_i)
			ds_last <= ds[ds_addr_i];
		if (ds_wr_i)
			ds[ds_addr_i] <= ds_wdata_i;
	end
endmodule // mabce_mem

`default_nettype wire

// ===== mabce_core_tb.sv
// self-checking bench for the execution core with its memory model
// assumes core and memory model share one 100 MHz clock
`default_nettype none

module mabce_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst, wdog, wake, pm_rd, ds_rd, ds_wr;
	logic        zero, carry, wait_o, stop_o, done, ez, ec;
	logic [23:0] pm_data;
	logic [11:0] pm_addr, pc_o, pc, r;
	logic [7:0]  ds_rdata, ds_addr, ds_wdata, acc, ea;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cycles = 0;

	mabce_core u_mabce_core (
		.CLK_I(clk), .RST_I(rst), .PM_DATA_I(pm_data),
		.DS_RDATA_I(ds_rdata), .WDOG_SEL_I(wdog), .WAKE_I(wake),
		.PM_ADDR_O(pm_addr), .PM_RD_O(pm_rd), .DS_ADDR_O(ds_addr),
		.DS_RD_O(ds_rd), .DS_WR_O(ds_wr), .DS_WDATA_O(ds_wdata),
		.ACC_O(acc), .ZERO_O(zero), .CARRY_O(carry), .PC_O(pc_o),
		.WAIT_O(wait_o), .STOP_O(stop_o), .DONE_O(done)
	);
	mabce_mem u_mabce_mem (
		.clk_i(clk), .pm_addr_i(pm_addr), .pm_rd_i(pm_rd),
		.pm_data_o(pm_data), .ds_addr_i(ds_addr), .ds_rd_i(ds_rd),
		.ds_wr_i(ds_wr), .ds_wdata_i(ds_wdata), .ds_rdata_o(ds_rdata)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp,
		input string msg);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s seen %h expected %h",
				$time, msg, seen, exp);
		end
	endtask

	task automatic dsw(input logic [7:0] ad, input logic [7:0] v);
		u_mabce_mem.ds[ad] = v;
	endtask

	task automatic dsc(input logic [7:0] ad, input logic [7:0] v);
		check(24'(u_mabce_mem.ds[ad]), 24'(v), "data byte");
	endtask

	// places one instruction at pc, runs it to the next fetch
	task automatic ex(input logic [23:0] i, input int n,
		input logic [11:0] np, input logic [7:0] a, input logic z,
		input logic c);
		int k;
		k = 0;
		check(24'(pm_addr), 24'(pc), "fetch address");
		u_mabce_mem.pm[pc] = i[7:0];
		u_mabce_mem.pm[pc + 12'h001] = i[15:8];
		u_mabce_mem.pm[pc + 12'h002] = i[23:16];
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (pm_rd !== 1'b1 && k < 8);
		check(24'(k), 24'(n), "cycle count");
		check(24'({pc_o, acc, zero, carry, done}), 24'({np, a, z, c, 1'b1}),
			"state after");
		pc = np;
		ea = a;
		ez = z;
		ec = c;
	endtask

	task automatic t_alu();
		dsw(8'h20, 8'h05);
		dsw(8'h80, 8'h30);
		dsw(8'h30, 8'h03);
		dsw(8'h81, 8'h31);
		dsw(8'h31, 8'hFF);
		ex(24'h0000CF, 4, pc + 12'h002, 8'h00, 1'b1, 1'b0);
		ex(24'h00F01F, 4, pc + 12'h002, 8'hF0, 1'b0, 1'b0);
		ex(24'h00201F, 4, pc + 12'h002, 8'h10, 1'b0, 1'b1);
		ex(24'h00183F, 4, pc + 12'h002, 8'h10, 1'b0, 1'b0);
		ex(24'h00115F, 4, pc + 12'h002, 8'h10, 1'b0, 1'b1);
		ex(24'h00105F, 4, pc + 12'h002, 8'h10, 1'b1, 1'b0);
		ex(24'h00107F, 4, pc + 12'h002, 8'h00, 1'b1, 1'b0);
		ex(24'h00200F, 4, pc + 12'h002, 8'h05, 1'b0, 1'b0);
		ex(24'h000007, 4, pc + 12'h001, 8'h08, 1'b0, 1'b0);
		ex(24'h000017, 4, pc + 12'h001, 8'h07, 1'b0, 1'b1);
		$display("alu test done");
	endtask

	task automatic t_acc();
		ex(24'h0000E7, 4, pc + 12'h001, 8'hF8, 1'b0, 1'b0);
		ex(24'h0000F7, 4, pc + 12'h001, 8'hF0, 1'b0, 1'b1);
		ex(24'h0000EF, 4, pc + 12'h002, 8'hE0, 1'b0, 1'b1);
		ex(24'h0000F7, 4, pc + 12'h001, 8'hC1, 1'b0, 1'b1);
		$display("accumulator test done");
	endtask

	task automatic t_incdec();
		dsw(8'h00, 8'hFF);
		dsw(8'hFE, 8'h01);
		dsw(8'h82, 8'h7F);
		dsw(8'h83, 8'h01);
		dsw(8'h80, 8'h60);
		dsw(8'h60, 8'hFF);
		dsw(8'h61, 8'hAA);
		ex(24'h00008F, 4, pc + 12'h002, ea, 1'b1, ec);
		ex(24'h00FEAF, 4, pc + 12'h002, ea, 1'b1, ec);
		ex(24'h00FF8F, 4, pc + 12'h002, 8'hC2, 1'b0, ec);
		ex(24'h000085, 4, pc + 12'h001, ea, 1'b0, ec);
		ex(24'h0000CD, 4, pc + 12'h001, ea, 1'b1, ec);
		ex(24'h000087, 4, pc + 12'h001, ea, 1'b1, ec);
		ex(24'h5561DF, 4, pc + 12'h003, ea, ez, ec);
		dsc(8'h00, 8'h00);
		dsc(8'hFE, 8'h00);
		dsc(8'h82, 8'h80);
		dsc(8'h83, 8'h00);
		dsc(8'h60, 8'h00);
		dsc(8'h61, 8'h00);
		$display("inc dec clear test done");
	endtask

	task automatic t_bits();
		dsw(8'h40, 8'h20);
		dsw(8'h50, 8'h00);
		dsw(8'h51, 8'hFF);
		ex(24'h7F40B3, 5, pc + 12'h081, ea, ez, 1'b1);
		ex(24'h8040A3, 5, pc + 12'h003, ea, ez, 1'b1);
		ex(24'h804003, 5, pc - 12'h07E, ea, ez, 1'b0);
		ex(24'h0050FB, 4, pc + 12'h002, ea, ez, ec);
		ex(24'h00510B, 4, pc + 12'h002, ea, ez, ec);
		dsc(8'h50, 8'h80);
		dsc(8'h51, 8'hFE);
		$display("bit test done");
	endtask

	task automatic t_short();
		logic [2:0]  cd;
		logic        t;
		logic [11:0] np;
		for (int s = 0; s < 2; s++) begin
			ex(24'h0000CF, 4, pc + 12'h002, 8'h00, 1'b1, 1'b0);
			if (s == 1)
				ex(24'h00015F, 4, pc + 12'h002, 8'h00, 1'b0, 1'b1);
			for (int i = 0; i < 4; i++) begin
				cd = 3'(2 * i);
				t = cd[2] ? (cd[1] ? ec : ez) : (cd[1] ? !ec : !ez);
				np = i[0] ? pc - 12'h00F : pc + 12'h010;
				np = t ? np : pc + 12'h001;
				ex({16'h0000, 4'hF, i[0], cd}, 2, np, ea, ez, ec);
			end
		end
		$display("short branch test done");
	endtask

	task automatic t_jump();
		ex(24'h0034A9, 4, 12'hA34, ea, ez, ec);
		ex(24'h0000CF, 4, pc + 12'h002, 8'h00, 1'b1, 1'b0);
		r = pc + 12'h002;
		ex(24'h002311, 4, 12'h123, ea, ez, ec);
		ex(24'h00011F, 4, pc + 12'h002, 8'h01, 1'b0, 1'b0);
		ex(24'h000095, 2, r, ea, 1'b1, 1'b0);
		r = pc + 12'h002;
		ex(24'h002311, 4, 12'h123, ea, ez, ec);
		ex(24'h00025F, 4, pc + 12'h002, ea, 1'b0, 1'b1);
		ex(24'h000055, 2, r, ea, ez, ec);
		$display("jump call test done");
	endtask

	task automatic t_halt(input logic [7:0] op, input logic wd,
		input logic st);
		int k;
		wdog = wd;
		ex(24'h000015, 2, pc + 12'h001, ea, ez, ec);
		ex(24'h000015, 2, pc + 12'h001, ea, ez, ec);
		u_mabce_mem.pm[pc] = op;
		repeat (4) @(posedge clk);
		#1;
		check(24'({wait_o, stop_o, pm_rd}), 24'({!st, st, 1'b0}), "halt");
		wake = 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (pm_rd !== 1'b1 && k < 8);
		wake = 1'b0;
		pc = pc + 12'h001;
		check(24'(pm_addr), 24'(pc), "resume address");
		$display("halt test done");
	endtask

	initial begin
		rst = 1'b1;
		wdog = 1'b0;
		wake = 1'b0;
		pc = mabce_pkg::RESET_PC;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		t_alu();
		t_acc();
		t_incdec();
		t_bits();
		t_short();
		t_jump();
		t_halt(8'h25, 1'b0, 1'b0);
		t_halt(8'hD5, 1'b0, 1'b1);
		t_halt(8'hD5, 1'b1, 1'b0);
		summarize();
	end
endmodule // mabce_core_tb

`default_nettype wire
